// file: src/uhig_pkg.sv
// Overview of operation
// - irq only when global enable set
// - bit 1 selects level or pulse
// - bit 2 polarity; processor must match
// - reset gives level, active low
// - events always flag; irq needs enables
// - write one clears flag, zero keeps
// - level irq holds until flags cleared
// - edge mode: one pulse per activation
// - pulse width from bits 15..0
// - started pulse always runs full width
// - bits 31..24 minimum spacing, 00h none
// - only flags kept, no order or time
// - runs on always-on clock during suspend
// - or mask bit with done bit raises
// - and mask needs all selected done bits
// - separate mask pair per category
// - async interval holds completions until timeout
// - done maps readable when irq raised
package uhig_pkg;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [11:0] mode_ctrl_off      = 12'h000;
  localparam logic [11:0] status_off         = 12'h004;
  localparam logic [11:0] enable_off         = 12'h008;
  localparam logic [11:0] pulse_shape_off    = 12'h00c;
  localparam logic [11:0] iso_or_off         = 12'h010;
  localparam logic [11:0] iso_and_off        = 12'h014;
  localparam logic [11:0] int_or_off         = 12'h018;
  localparam logic [11:0] int_and_off        = 12'h01c;
  localparam logic [11:0] atl_or_off         = 12'h020;
  localparam logic [11:0] atl_and_off        = 12'h024;
  localparam logic [11:0] atl_timeout_off    = 12'h028;
  localparam logic [11:0] iso_done_off       = 12'h02c;
  localparam logic [11:0] int_done_off       = 12'h030;
  localparam logic [11:0] atl_done_off       = 12'h034;

  // ----------------------------------------
  // fields and reset values
  // ----------------------------------------
  localparam int          global_en_bit      = 0;
  localparam int          trigger_bit        = 1;
  localparam int          polarity_bit       = 2;
  localparam int          interval_en_bit    = 3;
  localparam logic [3:0]  mode_ctrl_rst      = 4'h0;
  localparam int          width_lsb          = 0;
  localparam int          spacing_lsb        = 24;
  // about 500 ns at 40 MHz
  localparam int          pulse_rst_ns       = 500;
  localparam int          clk_period_ns      = 25;
  localparam logic [15:0] pulse_width_rst    = 16'((pulse_rst_ns + clk_period_ns - 1) / clk_period_ns);
  localparam logic [7:0]  spacing_rst        = 8'h00;
  // status bits 0..2 are descriptor-done events of iso, int, async
  localparam int          iso_done_evt       = 0;
  localparam int          int_done_evt       = 1;
  localparam int          atl_done_evt       = 2;
  localparam int          num_cats           = 3;
  // one spacing unit in cycles
  localparam logic [15:0] spacing_unit_cyc   = 16'h0028;

  typedef enum logic [1:0] {uhig_idle, uhig_pulse, uhig_space} uhig_state_t;

endpackage : uhig_pkg

// file: src/uhig_top.sv
`timescale 1ns/10ps
`default_nettype none
module uhig_top #(
  parameter int num_events = 16,
  parameter int num_desc   = 32
) (
  // clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic                       pready,
  output logic                       pslverr,
  output logic [31:0]                prdata,
  // event sources, one-cycle pulses from same-clock logic
  input  wire logic [num_events-1:0] event_set,
  // descriptor done strobes per category
  input  wire logic [num_desc-1:0]   iso_done_set,
  input  wire logic [num_desc-1:0]   int_done_set,
  input  wire logic [num_desc-1:0]   atl_done_set,
  // interrupt line
  output logic                       irq_out
);

  localparam int num_cats = uhig_pkg::num_cats;

  // status bits 0..2 carry the category events, and the bus is one word wide
  if (num_events < 3 || num_events > 32) begin : g_bad_events
    $error("num_events out of range");
  end
  if (num_desc < 1 || num_desc > 32) begin : g_bad_desc
    $error("num_desc out of range");
  end

  typedef struct packed {
    logic [3:0]                  mode;
    logic [num_events-1:0]       status;
    logic [num_events-1:0]       enable;
    logic [15:0]                 width;
    logic [7:0]                  spacing;
    logic [num_cats*num_desc-1:0] or_mask;
    logic [num_cats*num_desc-1:0] and_mask;
    logic [num_cats*num_desc-1:0] done;
    logic [31:0]                 atl_timeout;
    logic [31:0]                 atl_tmr;
    logic                        atl_tick;
    logic [15:0]                 cnt;
    logic [15:0]                 unit;
    uhig_pkg::uhig_state_t       st;
    logic                        active;
    logic                        irq_line;
    logic                        pready;
    logic                        pslverr;
    logic [31:0]                 prdata;
  } uhig_state_s_t;

  uhig_state_s_t s_r;
  uhig_state_s_t s_nxt;

  logic [num_desc-1:0] done_set [num_cats];
  logic [num_cats-1:0] cat_hit;
  logic [31:0]         wmask;
  logic                wr;
  logic                rd;
  logic                cause;

  always_comb begin
    done_set[0] = iso_done_set;
    done_set[1] = int_done_set;
    done_set[2] = atl_done_set;
  end

  // ----------------------------------------
  // descriptor done conditioning
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < num_cats; g++) begin : g_cat
      logic [num_desc-1:0] dn;
      logic [num_desc-1:0] om;
      logic [num_desc-1:0] am;
      assign dn = s_r.done[g*num_desc +: num_desc];
      assign om = s_r.or_mask[g*num_desc +: num_desc];
      assign am = s_r.and_mask[g*num_desc +: num_desc];
      // or mask wins; and mask only over bits not in or mask
      assign cat_hit[g] = |(dn & om) ||
                          ((|(am & ~om)) && ((dn & am & ~om) == (am & ~om)));
    end
  endgenerate

  generate
    for (g = 0; g < 32; g++) begin : g_strb
      assign wmask[g] = pstrb[g/8];
    end
  endgenerate

  assign wr = psel && penable && pwrite && !s_r.pready;
  assign rd = psel && penable && !pwrite && !s_r.pready;
  // level cause: any enabled flag pending
  assign cause = s_r.mode[uhig_pkg::global_en_bit] && |(s_r.status & s_r.enable);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic [31:0] rdv;
    logic [num_events-1:0] clr;
    logic [num_cats-1:0]   evt;
    rdv   = 32'h0000_0000;
    clr   = '0;
    evt   = '0;
    s_nxt = s_r;
    s_nxt.pready  = 1'b0;
    s_nxt.pslverr = 1'b0;

    // async timeout interval tick
    s_nxt.atl_tick = 1'b0;
    if (s_r.atl_timeout == 32'h0000_0000 || s_r.atl_tmr >= s_r.atl_timeout) begin
      s_nxt.atl_tmr  = 32'h0000_0000;
      s_nxt.atl_tick = 1'b1;
    end else begin
      s_nxt.atl_tmr = s_r.atl_tmr + 32'h0000_0001;
    end

    for (int c = 0; c < num_cats; c++) begin
      s_nxt.done[c*num_desc +: num_desc] = s_r.done[c*num_desc +: num_desc] | done_set[c];
    end
    evt[uhig_pkg::iso_done_evt] = cat_hit[0];
    evt[uhig_pkg::int_done_evt] = cat_hit[1];
    // with interval option, async completions wait for the timeout
    evt[uhig_pkg::atl_done_evt] = cat_hit[2] &&
                                  (!s_r.mode[uhig_pkg::interval_en_bit] || s_r.atl_tick);

    if (wr || rd) begin
      s_nxt.pready = 1'b1;
      if (paddr == uhig_pkg::mode_ctrl_off) begin
        rdv = {28'h0, s_r.mode};
        if (wr && pstrb[0]) s_nxt.mode = pwdata[3:0];
      end else if (paddr == uhig_pkg::status_off) begin
        rdv = 32'(s_r.status);
        if (wr) clr = num_events'(pwdata & wmask);
      end else if (paddr == uhig_pkg::enable_off) begin
        rdv = 32'(s_r.enable);
        if (wr) s_nxt.enable = num_events'((pwdata & wmask) | (32'(s_r.enable) & ~wmask));
      end else if (paddr == uhig_pkg::pulse_shape_off) begin
        rdv = {s_r.spacing, 8'h00, s_r.width};
        if (wr) begin
          if (pstrb[0]) s_nxt.width[7:0] = pwdata[7:0];
          if (pstrb[1]) s_nxt.width[15:8] = pwdata[15:8];
          if (pstrb[3]) s_nxt.spacing = pwdata[31:24];
        end
      end else if (paddr == uhig_pkg::atl_timeout_off) begin
        rdv = s_r.atl_timeout;
        if (wr) s_nxt.atl_timeout = (pwdata & wmask) | (s_r.atl_timeout & ~wmask);
      end else if (paddr >= uhig_pkg::iso_or_off && paddr <= uhig_pkg::atl_and_off && paddr[1:0] == 2'b00) begin
        for (int c = 0; c < num_cats; c++) begin
          if (paddr == uhig_pkg::iso_or_off + 12'(8 * c)) begin
            rdv = 32'(s_r.or_mask[c*num_desc +: num_desc]);
            if (wr) s_nxt.or_mask[c*num_desc +: num_desc] = num_desc'(pwdata);
          end else if (paddr == uhig_pkg::iso_and_off + 12'(8 * c)) begin
            rdv = 32'(s_r.and_mask[c*num_desc +: num_desc]);
            if (wr) s_nxt.and_mask[c*num_desc +: num_desc] = num_desc'(pwdata);
          end
        end
      end else if (paddr >= uhig_pkg::iso_done_off && paddr <= uhig_pkg::atl_done_off && paddr[1:0] == 2'b00) begin
        for (int c = 0; c < num_cats; c++) begin
          if (paddr == uhig_pkg::iso_done_off + 12'(4 * c)) begin
            rdv = 32'(s_r.done[c*num_desc +: num_desc]);
            // write one clears; new done wins over the clear
            if (wr) s_nxt.done[c*num_desc +: num_desc] =
                      (s_r.done[c*num_desc +: num_desc] & ~num_desc'(pwdata)) | done_set[c];
          end
        end
      end else begin
        s_nxt.pslverr = 1'b1;
      end
      if (rd) s_nxt.prdata = rdv;
    end

    // set wins over clear; only flags are kept
    s_nxt.status = (s_r.status & ~clr) | event_set;
    s_nxt.status[num_cats-1:0] = s_nxt.status[num_cats-1:0] | evt;

    // ----------------------------------------
    // output shaping
    // ----------------------------------------
    s_nxt.unit = (s_r.unit == 16'h0000) ? uhig_pkg::spacing_unit_cyc - 16'h0001 : s_r.unit - 16'h0001;
    case (s_r.st)
      uhig_pkg::uhig_idle: begin
        if (!s_r.mode[uhig_pkg::trigger_bit]) begin
          s_nxt.active = cause;
        end else if (cause) begin
          s_nxt.active = 1'b1;
          s_nxt.cnt    = (s_r.width == 16'h0000) ? 16'h0001 : s_r.width;
          s_nxt.st     = uhig_pkg::uhig_pulse;
        end else begin
          s_nxt.active = 1'b0;
        end
      end
      uhig_pkg::uhig_pulse: begin
        // runs out regardless of status clears
        if (s_r.cnt <= 16'h0001) begin
          s_nxt.active = 1'b0;
          s_nxt.cnt    = {8'h00, s_r.spacing};
          s_nxt.unit   = uhig_pkg::spacing_unit_cyc - 16'h0001;
          if (s_r.spacing == uhig_pkg::spacing_rst) begin
            s_nxt.st = uhig_pkg::uhig_idle;
          end else begin
            s_nxt.st = uhig_pkg::uhig_space;
          end
        end else begin
          s_nxt.cnt = s_r.cnt - 16'h0001;
        end
      end
      uhig_pkg::uhig_space: begin
        // events meanwhile stay latched and merge into one pulse
        if (s_r.unit == 16'h0000) begin
          if (s_r.cnt <= 16'h0001) begin
            s_nxt.st = uhig_pkg::uhig_idle;
          end else begin
            s_nxt.cnt = s_r.cnt - 16'h0001;
          end
        end
      end
      default: s_nxt.st = uhig_pkg::uhig_idle;
    endcase

    // line registered so a polarity change cannot glitch it
    s_nxt.irq_line = s_nxt.active ~^ s_nxt.mode[uhig_pkg::polarity_bit];
  end

  // ----------------------------------------
  // state register, on the always-on clock
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r             <= '0;
      s_r.mode        <= uhig_pkg::mode_ctrl_rst;
      s_r.width       <= uhig_pkg::pulse_width_rst;
      s_r.spacing     <= uhig_pkg::spacing_rst;
      s_r.st          <= uhig_pkg::uhig_idle;
      s_r.irq_line    <= ~uhig_pkg::mode_ctrl_rst[uhig_pkg::polarity_bit];
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pready  = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign prdata  = s_r.prdata;
  // polarity bit clear means active low
  assign irq_out = s_r.irq_line;

endmodule : uhig_top
`default_nettype wire

// file: verification/uhig_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module uhig_host_model (
  // clock and reset
  input  wire logic      pclk,
  input  wire logic      presetn,
  // line and the sense the processor input is set to
  input  wire logic      irq_out,
  input  wire logic      pol_high,
  // activations seen
  output var  logic [7:0] n_irq
);
  logic act_q;
  // counts edges only, a level held at the active sense is one activation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_q <= 1'b0;
      n_irq <= 8'h0;
    end else begin
      act_q <= (irq_out == pol_high);
      if ((irq_out == pol_high) && !act_q) begin
        n_irq <= n_irq + 8'h1;
      end
    end
  end
endmodule : uhig_host_model
`default_nettype wire

// file: verification/uhig_properties.sv
`timescale 1ns/10ps
`default_nettype none
module uhig_chk #(
  parameter int num_events = 16,
  parameter int num_desc   = 32
) (
  // bus
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  // interrupt line
  input wire logic        irq_out
);
  logic [2:0]  mode_r;
  logic [2:0]  mode_q;
  logic [15:0] width_r;
  logic [15:0] cnt_r;
  logic        act;
  logic        wr;
  assign act = (irq_out == mode_r[2]);
  assign wr  = psel && penable && pwrite && !pready;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r  <= 3'h0;
      mode_q  <= 3'h0;
      width_r <= uhig_pkg::pulse_width_rst;
      cnt_r   <= 16'h0;
    end else begin
      mode_q <= mode_r;
      // a polarity change flips the line without a real pulse, so restart
      cnt_r  <= (act && mode_r == mode_q) ? cnt_r + 16'h1 : 16'h0;
      if (wr && paddr == uhig_pkg::mode_ctrl_off) begin
        mode_r <= pwdata[2:0];
      end
      if (wr && paddr == uhig_pkg::pulse_shape_off) begin
        width_r <= pwdata[15:0];
      end
    end
  end
  // ----
  // properties
  // ----
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_take;
    psel && penable && !pready;
  endsequence
  sequence s_pulse_end;
    mode_r[1] && $fell(act) && cnt_r != 16'h0;
  endsequence
  chk_ready_answer: assert property (s_take |=> pready) else $error("no answer");
  chk_ready_single: assert property (pready |=> !pready) else $error("ready too long");
  chk_ready_idle: assert property (!psel |-> !pready) else $error("ready unselected");
  chk_err_unmapped: assert property (pready && (paddr > 12'h034 || paddr[1:0] != 2'b00) |-> pslverr)
    else $error("bad address accepted");
  chk_err_rdata: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0) else $error("error data");
  chk_reset_idle: assert property ($rose(presetn) |-> irq_out) else $error("line active at reset");
  chk_global_gate: assert property (!mode_r[0] && $stable(mode_r) |-> !act) else $error("line ungated");
  chk_level_hold: assert property (mode_r[1:0] == 2'b01 && $stable(mode_r) && act && !(psel && pwrite) |=> act)
    else $error("level dropped");
  chk_pulse_width: assert property (s_pulse_end |-> cnt_r == ((width_r == 16'h0) ? 16'h1 : width_r))
    else $error("pulse width");
endmodule : uhig_chk
bind uhig_top uhig_chk #(.num_events(num_events), .num_desc(num_desc)) i_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .prdata(prdata), .irq_out(irq_out));
`default_nettype wire

// file: verification/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic e;} uhig_row_t;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_out, pol_high, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, iso_d, int_d, atl_d;
  logic [15:0] event_set;
  logic [7:0]  n_irq, n0;
  int          n_fail = 0, compares = 0, cyc = 0;
  uhig_row_t   rows [7] = '{{1'b0, uhig_pkg::mode_ctrl_off, 32'h0, 1'b0}, {1'b0, uhig_pkg::pulse_shape_off,
    {16'h0, uhig_pkg::pulse_width_rst}, 1'b0}, {1'b1, uhig_pkg::pulse_shape_off, 32'h0100_0005, 1'b0},
    {1'b0, uhig_pkg::pulse_shape_off, 32'h0100_0005, 1'b0}, {1'b0, 12'h038, 32'h0, 1'b1},
    {1'b1, 12'h002, 32'h7, 1'b1}, {1'b0, uhig_pkg::mode_ctrl_off, 32'h0, 1'b0}};
  uhig_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(4'hf), .pready(pready), .pslverr(pslverr), .prdata(prdata), .event_set(event_set),
    .iso_done_set(iso_d), .int_done_set(int_d), .atl_done_set(atl_d), .irq_out(irq_out));
  uhig_host_model i_host (.pclk(pclk), .presetn(presetn), .irq_out(irq_out), .pol_high(pol_high), .n_irq(n_irq));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      n_fail = n_fail + 1;
      stop_test();
    end
  end
  task automatic stop_test();
    if (n_fail == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    e  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdc(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(rd, x);
  endtask : rdc
  task automatic pulse(input logic [15:0] ev, input logic [31:0] iso, input logic [31:0] itr, input logic [31:0] async_transfer_list);
    @(posedge pclk);
    event_set <= ev;
    iso_d     <= iso;
    int_d     <= itr;
    atl_d     <= async_transfer_list;
    @(posedge pclk);
    event_set <= 16'h0;
    iso_d     <= 32'h0;
    int_d     <= 32'h0;
    atl_d     <= 32'h0;
    repeat (4) @(posedge pclk);
  endtask : pulse
  initial begin
    {psel, penable, pwrite, paddr, pwdata, event_set, iso_d, int_d, atl_d, presetn, pol_high} = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({31'h0, irq_out}, 32'h1);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk({31'h0, e}, {31'h0, rows[i].e});
      if (rows[i].w) apb(1'b0, rows[i].a, 32'h0);
      chk(rd, rows[i].e ? 32'h0 : rows[i].d);
    end
    apb(1'b1, uhig_pkg::status_off, 32'hffff);
    apb(1'b1, uhig_pkg::enable_off, 32'h10);
    pulse(16'h0030, 32'h0, 32'h0, 32'h0);
    rdc(uhig_pkg::status_off, 32'h30);
    chk({31'h0, irq_out}, 32'h1);
    apb(1'b1, uhig_pkg::mode_ctrl_off, 32'h1);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq_out}, 32'h0);
    apb(1'b1, uhig_pkg::status_off, 32'h0);
    rdc(uhig_pkg::status_off, 32'h30);
    chk({31'h0, irq_out}, 32'h0);
    apb(1'b1, uhig_pkg::status_off, 32'h10);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq_out}, 32'h1);
    rdc(uhig_pkg::status_off, 32'h20);
    // ----
    // edge mode, active high, clear lands mid pulse
    // ----
    apb(1'b1, uhig_pkg::mode_ctrl_off, 32'h7);
    pol_high <= 1'b1;
    repeat (4) @(posedge pclk);
    n0 = n_irq;
    @(posedge pclk);
    event_set <= 16'h0010;
    @(posedge pclk);
    event_set <= 16'h0;
    while (irq_out !== 1'b1) @(posedge pclk);
    apb(1'b1, uhig_pkg::status_off, 32'h10);
    repeat (60) @(posedge pclk);
    chk({24'h0, n_irq}, {24'h0, n0 + 8'h1});
    chk({31'h0, irq_out}, 32'h0);
    apb(1'b1, uhig_pkg::iso_or_off, 32'h80);
    pulse(16'h0, 32'h80, 32'h0, 32'h0);
    rdc(uhig_pkg::status_off, 32'h21);
    apb(1'b1, uhig_pkg::int_and_off, 32'h16);
    pulse(16'h0, 32'h0, 32'h86, 32'h0);
    rdc(uhig_pkg::status_off, 32'h21);
    pulse(16'h0, 32'h0, 32'h10, 32'h0);
    rdc(uhig_pkg::status_off, 32'h23);
    rdc(uhig_pkg::int_done_off, 32'h96);
    // ----
    // async interval: timer sits at zero until a timeout is written
    // ----
    apb(1'b1, uhig_pkg::mode_ctrl_off, 32'hf);
    apb(1'b1, uhig_pkg::atl_or_off, 32'h1);
    apb(1'b1, uhig_pkg::atl_timeout_off, 32'hc8);
    pulse(16'h0, 32'h0, 32'h0, 32'h1);
    rdc(uhig_pkg::status_off, 32'h23);
    repeat (250) @(posedge pclk);
    rdc(uhig_pkg::status_off, 32'h27);
    rdc(uhig_pkg::atl_done_off, 32'h1);
    // ----
    // reset in mid run returns to level, active low
    // ----
    presetn  <= 1'b0;
    pol_high <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({31'h0, irq_out}, 32'h1);
    rdc(uhig_pkg::mode_ctrl_off, 32'h0);
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
